// ### verilog/ipe_pkg.sv
// Shared constants for the interrupt priority and enable register block
package ipe_pkg;

    // Bus geometry: each register takes one 32-bit word at four times its index
    localparam int MIN_ADR_W = 18;
    localparam int DATA_W = 32;

    // Register indices; byte address is the index shifted left by two
    localparam logic [15:0] IDX_PRIO_A = 16'hff20;
    localparam logic [15:0] IDX_PRIO_B = 16'hff21;
    localparam logic [15:0] IDX_TIMER_EN = 16'hff22;
    localparam logic [15:0] IDX_SERIAL_EN = 16'hff23;
    localparam logic [15:0] IDX_TIMER_FLAG = 16'hff26;
    localparam logic [15:0] IDX_SERIAL_FLAG = 16'hff27;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hff30;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'hff31;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hff32;

    // Field positions in the first priority register
    localparam int KEY_PRIO_LSB = 6;
    localparam int SERIAL_A_PRIO_LSB = 4;
    localparam int STOPWATCH_PRIO_LSB = 2;
    localparam int CLOCK_TIMER_PRIO_LSB = 0;

    // Field positions in the second priority register
    localparam int PTM_HI_PRIO_LSB = 4;
    localparam int PTM_LO_PRIO_LSB = 2;
    localparam int SERIAL_B_PRIO_LSB = 0;

    // Register widths
    localparam int PRIO_A_W = 8;
    localparam int PRIO_B_W = 6;
    localparam int TIMER_W = 7;
    localparam int SERIAL_W = 6;
    localparam int N_SRC = TIMER_W + SERIAL_W;

    // Values after reset
    localparam logic [PRIO_A_W-1:0] PRIO_A_RST = 8'h00;
    localparam logic [PRIO_B_W-1:0] PRIO_B_RST = 6'h00;
    localparam logic [TIMER_W-1:0] TIMER_EN_RST = 7'h00;
    localparam logic [SERIAL_W-1:0] SERIAL_EN_RST = 6'h00;
    localparam logic [N_SRC-1:0] FLAG_RST = 13'h0000;
    localparam logic [N_SRC-1:0] IRQ_ENABLE_RST = 13'h0000;

    // Source positions in the joined flag vector (timer flags low, serial high)
    localparam int SRC_CLOCK_TIMER_LSB = 0;
    localparam int SRC_STOPWATCH_LSB = 4;
    localparam int SRC_SERIAL_A_LSB = 7;
    localparam int SRC_SERIAL_B_LSB = 10;

    // Priority levels, field value equals level
    localparam logic [1:0] LEVEL0 = 2'h0;
    localparam logic [1:0] LEVEL3 = 2'h3;

    // Source groups as reported to the core; order is also the tie order
    typedef enum logic [1:0] {
        GRP_STOPWATCH,
        GRP_CLOCK_TIMER,
        GRP_SERIAL_A,
        GRP_SERIAL_B
    } ipe_group_e;

endpackage

// ### verilog/ipe_flag_bank.sv
// Sticky event flags: hardware sets, software clears by writing one
`timescale 1ns/1ps
module ipe_flag_bank #(
    parameter int WIDTH = ipe_pkg::N_SRC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] flag
);

    // Width check at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("ipe_flag_bank needs at least one flag");
    end

    // One flop per flag; set beats clear so no event is lost
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                flag[i] <= 1'b0;
            end else if (set[i]) begin
                flag[i] <= 1'b1; // RULE8
            end else if (clear[i]) begin
                flag[i] <= 1'b0; // RULE8
            end
        end

        property p_flag_set;
            @(posedge clock) disable iff (rst)
            set[i] |=> flag[i];
        endproperty
        a_flag_set: assert property (p_flag_set) else $error("Flag missed its event"); // RULE8

        property p_flag_clear;
            @(posedge clock) disable iff (rst)
            (clear[i] && !set[i]) |=> !flag[i];
        endproperty
        a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared by write of one"); // RULE8

        property p_flag_hold;
            @(posedge clock) disable iff (rst)
            (!clear[i] && !set[i]) |=> (flag[i] == $past(flag[i]));
        endproperty
        a_flag_hold: assert property (p_flag_hold) else $error("Flag changed without cause"); // RULE8
    end

endmodule

// ### verilog/ipe_intc.sv
// Interrupt priority, enable and factor flag registers with core request output
//
// Operation
// RULE1 - First priority register: key 7:6, serial A 5:4, stopwatch 3:2, clock timer 1:0.
// RULE2 - Second priority register: timers 3-2 at 5:4, timers 1-0 at 3:2, serial B 1:0.
// RULE3 - Each two-bit field is the priority level itself, 0 to 3.
// RULE4 - Stopwatch 100, 10, 1 Hz enables in bits 6:4, one permits, reset zero.
// RULE5 - Clock timer 32, 8, 2, 1 Hz enables in bits 3:0, reset zero.
// RULE6 - Serial B error enable bit 5, receive enable bit 4.
// RULE7 - Serial B transmit bit 3, serial A error, receive, transmit bits 2:0.
// RULE8 - Factor flags read one after their event; writing one clears, zero holds.
// RULE9 - Request the core only for flagged and enabled sources, carrying their level.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module ipe_intc #(
    parameter int ADR_W = ipe_pkg::MIN_ADR_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ipe_pkg::DATA_W-1:0] wb_dat_i,
    output logic [ipe_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ipe_pkg::TIMER_W-1:0] timer_evt,
    input wire logic [ipe_pkg::SERIAL_W-1:0] serial_evt,
    output logic cpu_irq_req,
    output logic [1:0] cpu_irq_level,
    output logic [1:0] cpu_irq_group,
    output logic irq,
    output logic [1:0] key_input_priority,
    output logic [1:0] prog_timer_hi_pair_priority,
    output logic [1:0] prog_timer_lo_pair_priority
);

    // Address width must reach the register indices
    if (ADR_W < ipe_pkg::MIN_ADR_W) begin : g_bad_adr
        $error("ipe_intc needs an address of at least 18 bits");
    end

    // Register storage
    logic [ipe_pkg::PRIO_A_W-1:0] interrupt_priority_a;
    logic [ipe_pkg::PRIO_B_W-1:0] interrupt_priority_b;
    logic [ipe_pkg::TIMER_W-1:0] timer_interrupt_enable;
    logic [ipe_pkg::SERIAL_W-1:0] serial_interrupt_enable;
    logic [ipe_pkg::N_SRC-1:0] irq_enable;
    logic [ipe_pkg::N_SRC-1:0] flags;

    // Bus decode
    logic bus_req;
    logic [15:0] reg_idx;
    logic wr_commit;
    logic wr_lo;
    logic wr_hi;
    logic [ipe_pkg::DATA_W-1:0] rd_mux;

    // Flag control and request selection
    logic [ipe_pkg::N_SRC-1:0] flag_set;
    logic [ipe_pkg::N_SRC-1:0] flag_clear;
    logic [ipe_pkg::N_SRC-1:0] src_enable;
    logic [ipe_pkg::N_SRC-1:0] pending;
    logic [3:0] grp_pend;
    logic [1:0] grp_level [4];
    logic next_req;
    logic [1:0] next_level;
    logic [1:0] next_group;

    // Upper address bits above the index are not decoded, so the map aliases
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign reg_idx = wb_adr_i[17:2];

    // A write lands on the edge where the master sees ack, never earlier
    assign wr_commit = bus_req & wb_ack_o & wb_we_i;
    assign wr_lo = wr_commit & wb_sel_i[0];
    assign wr_hi = wr_commit & wb_sel_i[1];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Read data registered together with ack; zero outside a read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_mux;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // Read multiplexer; reserved bits and unmapped words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            ipe_pkg::IDX_PRIO_A: begin
                rd_mux[ipe_pkg::PRIO_A_W-1:0] = interrupt_priority_a; // RULE1
            end
            ipe_pkg::IDX_PRIO_B: begin
                rd_mux[ipe_pkg::PRIO_B_W-1:0] = interrupt_priority_b; // RULE2
            end
            ipe_pkg::IDX_TIMER_EN: begin
                rd_mux[ipe_pkg::TIMER_W-1:0] = timer_interrupt_enable;
            end
            ipe_pkg::IDX_SERIAL_EN: begin
                rd_mux[ipe_pkg::SERIAL_W-1:0] = serial_interrupt_enable;
            end
            ipe_pkg::IDX_TIMER_FLAG: begin
                rd_mux[ipe_pkg::TIMER_W-1:0] = flags[ipe_pkg::TIMER_W-1:0]; // RULE8
            end
            ipe_pkg::IDX_SERIAL_FLAG: begin
                rd_mux[ipe_pkg::SERIAL_W-1:0] = flags[ipe_pkg::N_SRC-1:ipe_pkg::TIMER_W]; // RULE8
            end
            ipe_pkg::IDX_IRQ_STATUS: begin
                rd_mux[ipe_pkg::N_SRC-1:0] = flags;
            end
            ipe_pkg::IDX_IRQ_ENABLE: begin
                rd_mux[ipe_pkg::N_SRC-1:0] = irq_enable;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // First priority register, all four fields in byte lane 0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_priority_a <= ipe_pkg::PRIO_A_RST; // RULE1
        end else if (wr_lo && reg_idx == ipe_pkg::IDX_PRIO_A) begin
            interrupt_priority_a <= wb_dat_i[ipe_pkg::PRIO_A_W-1:0]; // RULE1
        end
    end

    // Second priority register, top two bits reserved
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_priority_b <= ipe_pkg::PRIO_B_RST; // RULE2
        end else if (wr_lo && reg_idx == ipe_pkg::IDX_PRIO_B) begin
            interrupt_priority_b <= wb_dat_i[ipe_pkg::PRIO_B_W-1:0]; // RULE2
        end
    end

    // Timer enables: stopwatch in 6:4, clock timer in 3:0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_interrupt_enable <= ipe_pkg::TIMER_EN_RST; // RULE4 RULE5
        end else if (wr_lo && reg_idx == ipe_pkg::IDX_TIMER_EN) begin
            timer_interrupt_enable <= wb_dat_i[ipe_pkg::TIMER_W-1:0]; // RULE4 RULE5
        end
    end

    // Serial enables: serial B in 5:3, serial A in 2:0
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_interrupt_enable <= ipe_pkg::SERIAL_EN_RST; // RULE7
        end else if (wr_lo && reg_idx == ipe_pkg::IDX_SERIAL_EN) begin
            serial_interrupt_enable <= wb_dat_i[ipe_pkg::SERIAL_W-1:0]; // RULE6 RULE7
        end
    end

    // Line enable for the interrupt output, split over two byte lanes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_enable <= ipe_pkg::IRQ_ENABLE_RST;
        end else if (reg_idx == ipe_pkg::IDX_IRQ_ENABLE) begin
            if (wr_lo) begin
                irq_enable[7:0] <= wb_dat_i[7:0];
            end
            if (wr_hi) begin
                irq_enable[ipe_pkg::N_SRC-1:8] <= wb_dat_i[ipe_pkg::N_SRC-1:8];
            end
        end
    end

    // Clear by writing one to a flag word or to the clear register
    always_comb begin
        flag_clear = '0;
        if (wr_lo && reg_idx == ipe_pkg::IDX_TIMER_FLAG) begin
            flag_clear[ipe_pkg::TIMER_W-1:0] = wb_dat_i[ipe_pkg::TIMER_W-1:0]; // RULE8
        end
        if (wr_lo && reg_idx == ipe_pkg::IDX_SERIAL_FLAG) begin
            flag_clear[ipe_pkg::N_SRC-1:ipe_pkg::TIMER_W] = wb_dat_i[ipe_pkg::SERIAL_W-1:0]; // RULE8
        end
        if (wr_lo && reg_idx == ipe_pkg::IDX_IRQ_CLEAR) begin
            flag_clear[7:0] = wb_dat_i[7:0];
        end
        if (wr_hi && reg_idx == ipe_pkg::IDX_IRQ_CLEAR) begin
            flag_clear[ipe_pkg::N_SRC-1:8] = wb_dat_i[ipe_pkg::N_SRC-1:8];
        end
    end

    // Events arrive on this clock, so no synchroniser is needed
    assign flag_set = {serial_evt, timer_evt};

    ipe_flag_bank #(
        .WIDTH(ipe_pkg::N_SRC)
    ) u_flags (
        .clock(clock),
        .rst(rst),
        .set(flag_set),
        .clear(flag_clear),
        .flag(flags)
    );

    // Only a flag with its enable bit may raise a request
    assign src_enable = {serial_interrupt_enable, timer_interrupt_enable};
    assign pending = flags & src_enable; // RULE9

    // Collapse per-source pending into the four prioritised groups
    assign grp_pend[0] = |pending[ipe_pkg::SRC_STOPWATCH_LSB +: 3];
    assign grp_pend[1] = |pending[ipe_pkg::SRC_CLOCK_TIMER_LSB +: 4];
    assign grp_pend[2] = |pending[ipe_pkg::SRC_SERIAL_A_LSB +: 3];
    assign grp_pend[3] = |pending[ipe_pkg::SRC_SERIAL_B_LSB +: 3];

    // Field value is the level itself, no remapping
    assign grp_level[0] = interrupt_priority_a[ipe_pkg::STOPWATCH_PRIO_LSB +: 2]; // RULE3
    assign grp_level[1] = interrupt_priority_a[ipe_pkg::CLOCK_TIMER_PRIO_LSB +: 2]; // RULE3
    assign grp_level[2] = interrupt_priority_a[ipe_pkg::SERIAL_A_PRIO_LSB +: 2]; // RULE3
    assign grp_level[3] = interrupt_priority_b[ipe_pkg::SERIAL_B_PRIO_LSB +: 2]; // RULE3

    // Highest level wins; equal levels go to the lower group number
    always_comb begin
        next_req = 1'b0;
        next_level = ipe_pkg::LEVEL0;
        next_group = 2'h0;
        for (int g = 0; g < 4; g++) begin
            if (grp_pend[g] && (!next_req || grp_level[g] > next_level)) begin
                next_req = 1'b1; // RULE9
                next_level = grp_level[g]; // RULE9
                next_group = 2'(g);
            end
        end
    end

    // Request to the core, registered so it is glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_irq_req <= 1'b0;
            cpu_irq_level <= ipe_pkg::LEVEL0;
            cpu_irq_group <= 2'h0;
        end else begin
            cpu_irq_req <= next_req; // RULE9
            cpu_irq_level <= next_level; // RULE9
            cpu_irq_group <= next_group;
        end
    end

    // Level interrupt line gated by its own enable register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & irq_enable);
        end
    end

    // Priority fields of sources handled elsewhere, passed out registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_input_priority <= ipe_pkg::LEVEL0;
            prog_timer_hi_pair_priority <= ipe_pkg::LEVEL0;
            prog_timer_lo_pair_priority <= ipe_pkg::LEVEL0;
        end else begin
            key_input_priority <= interrupt_priority_a[ipe_pkg::KEY_PRIO_LSB +: 2]; // RULE1
            prog_timer_hi_pair_priority <= interrupt_priority_b[ipe_pkg::PTM_HI_PRIO_LSB +: 2]; // RULE2
            prog_timer_lo_pair_priority <= interrupt_priority_b[ipe_pkg::PTM_LO_PRIO_LSB +: 2]; // RULE2
        end
    end

    // Checks on the register map and the core request
    property p_prio_a_write;
        @(posedge clock) disable iff (rst)
        (wr_lo && reg_idx == ipe_pkg::IDX_PRIO_A) |=> ##1 (key_input_priority == $past(wb_dat_i[7:6], 2));
    endproperty
    a_prio_a_write: assert property (p_prio_a_write) else $error("Key priority field not stored"); // RULE1

    property p_prio_b_write;
        @(posedge clock) disable iff (rst)
        (wr_lo && reg_idx == ipe_pkg::IDX_PRIO_B) |=> ##1
            (prog_timer_lo_pair_priority == $past(wb_dat_i[3:2], 2));
    endproperty
    a_prio_b_write: assert property (p_prio_b_write) else $error("Timer pair priority not stored"); // RULE2

    property p_level_direct;
        @(posedge clock) disable iff (rst)
        (next_req && next_group == 2'(ipe_pkg::GRP_SERIAL_B)) |=>
            (cpu_irq_level == $past(interrupt_priority_b[1:0]));
    endproperty
    a_level_direct: assert property (p_level_direct) else $error("Request level differs from field"); // RULE3

    property p_top_level;
        @(posedge clock) disable iff (rst)
        (grp_pend[0] && grp_level[0] == ipe_pkg::LEVEL3) |=> (cpu_irq_req && cpu_irq_level == ipe_pkg::LEVEL3);
    endproperty
    a_top_level: assert property (p_top_level) else $error("Level three request lost"); // RULE3

    property p_stopwatch_en;
        @(posedge clock) disable iff (rst)
        (wr_lo && reg_idx == ipe_pkg::IDX_TIMER_EN) |=> (timer_interrupt_enable[6:4] == $past(wb_dat_i[6:4]));
    endproperty
    a_stopwatch_en: assert property (p_stopwatch_en) else $error("Stopwatch enables not stored"); // RULE4

    property p_clock_timer_block;
        @(posedge clock) disable iff (rst)
        (timer_interrupt_enable[3:0] == 4'h0 && serial_interrupt_enable == 6'h00
            && timer_interrupt_enable[6:4] == 3'h0) |=> !cpu_irq_req;
    endproperty
    a_clock_timer_block: assert property (p_clock_timer_block) else $error("Request with all enables off"); // RULE5

    property p_serial_b_en;
        @(posedge clock) disable iff (rst)
        (wr_lo && reg_idx == ipe_pkg::IDX_SERIAL_EN) |=> (serial_interrupt_enable[5:4] == $past(wb_dat_i[5:4]));
    endproperty
    a_serial_b_en: assert property (p_serial_b_en) else $error("Serial B enables not stored"); // RULE6

    property p_serial_rest_en;
        @(posedge clock) disable iff (rst)
        (wr_lo && reg_idx == ipe_pkg::IDX_SERIAL_EN) |=> (serial_interrupt_enable[3:0] == $past(wb_dat_i[3:0]));
    endproperty
    a_serial_rest_en: assert property (p_serial_rest_en) else $error("Serial transmit enables not stored"); // RULE7

    property p_flag_readback;
        @(posedge clock) disable iff (rst)
        (bus_req && !wb_we_i && !wb_ack_o && reg_idx == ipe_pkg::IDX_TIMER_FLAG && flags[6]) |=>
            (wb_ack_o && wb_dat_o[6]);
    endproperty
    a_flag_readback: assert property (p_flag_readback) else $error("Flag not seen on read"); // RULE8

    property p_req_needs_enable;
        @(posedge clock) disable iff (rst)
        (pending == '0) |=> !cpu_irq_req;
    endproperty
    a_req_needs_enable: assert property (p_req_needs_enable) else $error("Request without enabled flag"); // RULE9

    property p_req_follows;
        @(posedge clock) disable iff (rst)
        (pending != '0) |=> cpu_irq_req;
    endproperty
    a_req_follows: assert property (p_req_follows) else $error("Enabled flag gave no request"); // RULE9

    property p_ack_single;
        @(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("Ack held two cycles");

endmodule

// ### dv/ipe_core_model.sv
// Behavioural model of the core side that accepts interrupt requests
`timescale 1ns/1ps
module ipe_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic req,
    input wire logic [1:0] level,
    input wire logic [1:0] group,
    output logic [1:0] taken_level,
    output logic [1:0] taken_group
);
    // Core only latches while a request stands; idle values are not trusted
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            taken_level <= 2'h0;
            taken_group <= 2'h0;
        end else if (req) begin
            taken_level <= level;
            taken_group <= group;
        end
    end
endmodule

// ### dv/testbench.sv
// Self-checking bench for the interrupt priority and enable block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [17:0] adr = 18'h00000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [6:0] tevt = 7'h00;
    logic [5:0] sevt = 6'h00;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack;
    logic req;
    logic irq;
    logic [1:0] lvl;
    logic [1:0] grp;
    logic [1:0] keyp;
    logic [1:0] pthi;
    logic [1:0] ptlo;
    logic [1:0] core_lvl;
    logic [1:0] core_grp;
    int err_count = 0;
    int tests_run = 0;

    ipe_intc dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_evt(tevt), .serial_evt(sevt), .cpu_irq_req(req), .cpu_irq_level(lvl),
        .cpu_irq_group(grp), .irq(irq), .key_input_priority(keyp),
        .prog_timer_hi_pair_priority(pthi), .prog_timer_lo_pair_priority(ptlo));

    ipe_core_model core (.clock(clock), .rst(rst), .req(req), .level(lvl), .group(grp),
        .taken_level(core_lvl), .taken_group(core_grp));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end

    task automatic final_report();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic cycle; request held until ack is seen at a rising edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h3;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_count++;
            final_report();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h00000000);
        chk(rd, exp);
    endtask

    // One-cycle event pulse, then time for flag and request to settle
    task automatic pulse(input logic [6:0] t, input logic [5:0] s);
        @(posedge clock);
        tevt <= t;
        sevt <= s;
        @(posedge clock);
        tevt <= 7'h00;
        sevt <= 6'h00;
        repeat (2) @(posedge clock);
    endtask

    task automatic t_reset();
        rchk(16'hff20, 32'h0);
        rchk(16'hff21, 32'h0);
        rchk(16'hff22, 32'h0);
        rchk(16'hff23, 32'h0);
        rchk(16'hff26, 32'h0);
    endtask

    task automatic t_regs();
        bus(1'b1, 16'hff20, 32'he4);
        rchk(16'hff20, 32'he4);
        bus(1'b1, 16'hff21, 32'hff);
        rchk(16'hff21, 32'h3f);
        bus(1'b1, 16'hff21, 32'h27);
        // Priority outputs trail the register by one edge
        repeat (2) @(posedge clock);
        chk({30'h0, keyp}, 32'h3);
        chk({30'h0, pthi}, 32'h2);
        chk({30'h0, ptlo}, 32'h1);
        bus(1'b1, 16'hff22, 32'hff);
        rchk(16'hff22, 32'h7f);
        bus(1'b1, 16'hff23, 32'hff);
        rchk(16'hff23, 32'h3f);
    endtask

    task automatic t_flags();
        pulse(7'h40, 6'h00);
        rchk(16'hff26, 32'h40);
        bus(1'b1, 16'hff26, 32'h00);
        rchk(16'hff26, 32'h40);
        bus(1'b1, 16'hff26, 32'h40);
        rchk(16'hff26, 32'h00);
        pulse(7'h00, 6'h20);
        rchk(16'hff27, 32'h20);
        bus(1'b1, 16'hff27, 32'h20);
        rchk(16'hff27, 32'h00);
    endtask

    // Stopwatch at level 1, then serial B at level 3 overtakes it
    task automatic t_request();
        pulse(7'h40, 6'h00);
        chk({29'h0, req, lvl}, 32'h5);
        chk({30'h0, grp}, 32'h0);
        pulse(7'h00, 6'h20);
        chk({29'h0, req, lvl}, 32'h7);
        // Core latches one edge after the request changes
        @(posedge clock);
        chk({28'h0, core_grp, core_lvl}, 32'hf);
        bus(1'b1, 16'hff26, 32'h7f);
        bus(1'b1, 16'hff27, 32'h3f);
        repeat (2) @(posedge clock);
        chk({31'h0, req}, 32'h0);
        bus(1'b1, 16'hff22, 32'h00);
        pulse(7'h01, 6'h00);
        chk({31'h0, req}, 32'h0);
        rchk(16'hff26, 32'h01);
        // Stopwatch raised to level 3 must be carried at that level
        bus(1'b1, 16'hff20, 32'h0c);
        bus(1'b1, 16'hff22, 32'h40);
        pulse(7'h40, 6'h00);
        chk({29'h0, req, lvl}, 32'h7);
        chk({30'h0, grp}, 32'h0);
        bus(1'b1, 16'hff26, 32'h40);
    endtask

    // Masked, enabled, then cleared; an unmapped word drops writes
    task automatic t_irq();
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 16'hff32, 32'h1);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        rchk(16'hff30, 32'h1);
        rchk(16'hff31, 32'h0);
        bus(1'b1, 16'hff31, 32'h1);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rchk(16'hff30, 32'h0);
        bus(1'b1, 16'hff40, 32'hffff);
        rchk(16'hff40, 32'h0);
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_flags();
        t_request();
        t_irq();
        final_report();
    end
endmodule
